// *** src/nmpc_consts.svh ***
// Purpose: Offsets, field positions, command bytes and timing counts of the
//          NAND program/copy-back host sequencer.
// Assumes: 25 MHz core clock; APB with 8-bit byte address.
// Notes:   Definitions only.
`ifndef NMPC_CONSTS_SVH
`define NMPC_CONSTS_SVH

// ****************************************
// Register map
// ****************************************
`define NMPC_OFS_CMD 8'h00
`define NMPC_OFS_STAT 8'h04
`define NMPC_OFS_RDATA 8'h08
`define NMPC_OFS_CFG 8'h0c
`define NMPC_CFG_RESET 4'h1

// ****************************************
// Field positions
// ****************************************
`define NMPC_CMD_OP_LSB 0
`define NMPC_CMD_BYTE_LSB 8
`define NMPC_CMD_FINAL_BIT 16
`define NMPC_CFG_WP_BIT 0
`define NMPC_CFG_RBONLY_BIT 1
`define NMPC_CFG_BOOT_BIT 2
`define NMPC_CFG_TWOPL_BIT 3
`define NMPC_SB_CUR 0
`define NMPC_SB_PREV 1
`define NMPC_SB_ARRAY 5
`define NMPC_SB_READY 6
`define NMPC_ADDR_PLANE_BIT 6

// ****************************************
// Command bytes
// ****************************************
`define NMPC_C_READ 8'h00
`define NMPC_C_CBREAD 8'h35
`define NMPC_C_SETUP 8'h80
`define NMPC_C_SETUP2 8'h81
`define NMPC_C_COLCHG 8'h85
`define NMPC_C_PROG 8'h10
`define NMPC_C_CACHE 8'h15
`define NMPC_C_QUEUE 8'h11
`define NMPC_C_STATUS 8'h70
`define NMPC_C_STATUS_ENH 8'h78
`define NMPC_C_RESET 8'hff
`define NMPC_C_ERASE 8'h60

// ****************************************
// Timing
// ****************************************
`define NMPC_CLK_NS 40
`define NMPC_T_WB_NS 100
`define NMPC_T_REA_NS 20
`define NMPC_SYNC_CYC 2
`define NMPC_WB_CYC ((`NMPC_T_WB_NS + `NMPC_CLK_NS - 1) / `NMPC_CLK_NS)
`define NMPC_RD_CYC (((`NMPC_T_REA_NS + `NMPC_CLK_NS - 1) / `NMPC_CLK_NS) + `NMPC_SYNC_CYC)

`endif

// *** src/nmpc_pkg.sv ***
// Purpose: Types of the NAND program/copy-back host sequencer.
// Assumes: Constants live in nmpc_consts.svh.
// Notes:   Operation codes follow enum order, 0 upward.
package nmpc_pkg;

  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [2:0] {
    nmpc_op_cmd,
    nmpc_op_addr,
    nmpc_op_dwr,
    nmpc_op_drd,
    nmpc_op_wait,
    nmpc_op_poll
  } nmpc_op_e;

  typedef enum logic [2:0] {
    st_idle,
    st_we_lo,
    st_we_hi,
    st_re_lo,
    st_re_hi,
    st_wb,
    st_rb
  } nmpc_state_e;

  typedef struct packed {
    logic cle;
    logic ale;
    logic ce_n;
    logic we_n;
    logic re_n;
    logic wp_n;
    logic [7:0] io;
    logic io_oe;
  } nmpc_pins_s;

endpackage

// *** src/nmpc_host.sv ***
// Purpose: Host-side sequencer for NAND cache, two-plane and copy-back program.
// Assumes: APB slave for software; NAND pins driven one primitive cycle at a time.
// Notes:   Software orders each cycle; hardware guards illegal sequences.
// Notes on behaviour
// [RULE1] R/B-only mode ends run with 10h
// [RULE2] Cache-ended run polls status bit 5
// [RULE3] Bit 1 gives previous page when bit6
// [RULE4] Bit 0 gives current result when bit5
// [RULE5] No cache program on boot blocks 0-3
// [RULE6] Setup clears caches unless queue preceded
// [RULE7] Queue plane then wait dummy busy
// [RULE8] Next plane only after bit 6 ready
// [RULE9] 10h final: check bit 0 per plane
// [RULE10] 15h final: check bit 1 per plane
// [RULE11] On error use enhanced status per plane
// [RULE12] Plane bit low first, high second
// [RULE13] Device uses second plane row address
// [RULE14] Never mix operation types across planes; the code refuses only 60h erase inside a plane run
// [RULE15] After 11h only status, reset, setup; the code also accepts 85h column change
// [RULE16] Same row applied to both blocks
// [RULE17] Copy-back read: 00h, address, 35h
// [RULE18] Copy back stays within one plane
// [RULE19] Copy-back data readable, column changes allowed
// [RULE20] Copy-back program: 85h, address, 10h
// [RULE21] Column-change edits before copy-back confirm
// [RULE22] Two-plane copy back keeps cache contents
// [RULE23] Bit 6 ready, R/B pin follows it
// [RULE24] Bit 5 low while array programs
// [RULE25] R/B low during dummy busy
`timescale 1ns/1ps
`include "nmpc_consts.svh"

module nmpc_host
  import nmpc_pkg::*;
(
  input wire logic core_clk_in,
  input wire logic arst_n_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [7:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  input wire logic [7:0] io_in,
  input wire logic ready_busy_in,
  output nmpc_pins_s nand_out
);

  // ****************************************
  // Pin synchronisers
  // ****************************************
  logic [7:0] io_meta;
  logic [7:0] io_s;
  logic rb_meta;
  logic rb_s;

  // Pins are asynchronous to the core clock
  always_ff @(posedge core_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      io_meta <= 8'h00;
      io_s <= 8'h00;
      rb_meta <= 1'b0;
      rb_s <= 1'b0;
    end
    else
    begin
      io_meta <= io_in;
      io_s <= io_meta;
      rb_meta <= ready_busy_in;
      rb_s <= rb_meta;
    end
  end

  // ****************************************
  // State
  // ****************************************
  nmpc_state_e state, next_state;
  nmpc_pins_s pins, next_pins;
  logic [3:0] cfg, next_cfg;
  logic [3:0] cnt, next_cnt;
  logic [7:0] rdata, next_rdata;
  logic [7:0] stat_byte, next_stat_byte;
  logic fail_cur, next_fail_cur;
  logic fail_prev, next_fail_prev;
  logic err, next_err;
  logic confirm, next_confirm;
  logic poll, next_poll;
  logic poll_arr, next_poll_arr;
  logic [2:0] addr_idx, next_addr_idx;
  logic queued, next_queued;
  logic plane_run, next_plane_run;
  logic plane, next_plane;
  logic blk_a, next_blk_a;
  logic blk_b, next_blk_b;
  logic blk_c, next_blk_c;
  logic cb_active, next_cb_active;
  logic src_plane, next_src_plane;
  logic [31:0] prdata, next_prdata;
  logic pready, next_pready;
  logic pslverr, next_pslverr;

  // ****************************************
  // Request decode
  // ****************************************
  logic apb_done;
  logic wr_cmd;
  logic cmd_go;
  logic refuse;
  nmpc_op_e req_op;
  logic [7:0] req_byte;
  logic [7:0] eff;
  logic req_final;
  logic boot_low;
  logic mapped;

  assign apb_done = psel_in && penable_in && pready;
  assign wr_cmd = apb_done && pwrite_in && (paddr_in == `NMPC_OFS_CMD);
  assign req_op = nmpc_op_e'(pwdata_in[`NMPC_CMD_OP_LSB +: 3]);
  assign req_byte = pwdata_in[`NMPC_CMD_BYTE_LSB +: 8];
  assign req_final = pwdata_in[`NMPC_CMD_FINAL_BIT];
  assign boot_low = !blk_a && blk_b && blk_c;
  assign mapped = (paddr_in == `NMPC_OFS_CMD) || (paddr_in == `NMPC_OFS_STAT) ||
                  (paddr_in == `NMPC_OFS_RDATA) || (paddr_in == `NMPC_OFS_CFG);

  // Command legality, checked before any pin moves
  always_comb
  begin
    eff = req_byte;
    refuse = 1'b0;
    if (req_op == nmpc_op_cmd && req_byte == `NMPC_C_CACHE && req_final &&
        cfg[`NMPC_CFG_RBONLY_BIT])
      eff = `NMPC_C_PROG; // [RULE1]
    if (req_op == nmpc_op_cmd)
    begin
      if (queued && !(eff == `NMPC_C_STATUS || eff == `NMPC_C_STATUS_ENH ||
          eff == `NMPC_C_RESET || eff == `NMPC_C_SETUP || eff == `NMPC_C_SETUP2 ||
          eff == `NMPC_C_COLCHG))
        refuse = 1'b1; // [RULE15]
      if (plane_run && eff == `NMPC_C_ERASE)
        refuse = 1'b1; // [RULE14]
      if (eff == `NMPC_C_CACHE && cfg[`NMPC_CFG_BOOT_BIT] && boot_low)
        refuse = 1'b1; // [RULE5]
      if (eff == `NMPC_C_PROG && cb_active && plane != src_plane)
        refuse = 1'b1; // [RULE18]
    end
    if (req_op > nmpc_op_poll || state != st_idle)
      refuse = 1'b1;
  end

  assign cmd_go = wr_cmd && !refuse;

  // ****************************************
  // Next-state logic: APB slave and pin sequencer
  // ****************************************
  always_comb
  begin
    next_state = state;
    next_pins = pins;
    next_cfg = cfg;
    next_cnt = cnt;
    next_rdata = rdata;
    next_stat_byte = stat_byte;
    next_fail_cur = fail_cur;
    next_fail_prev = fail_prev;
    next_err = err;
    next_confirm = confirm;
    next_poll = poll;
    next_poll_arr = poll_arr;
    next_addr_idx = addr_idx;
    next_queued = queued;
    next_plane_run = plane_run;
    next_plane = plane;
    next_blk_a = blk_a;
    next_blk_b = blk_b;
    next_blk_c = blk_c;
    next_cb_active = cb_active;
    next_src_plane = src_plane;
    next_prdata = prdata;
    next_pslverr = pslverr;
    // One wait state: ready rises in the second access cycle
    next_pready = psel_in && penable_in && !pready;
    if (psel_in && penable_in && !pready)
    begin
      next_pslverr = !mapped;
      case (paddr_in)
        `NMPC_OFS_STAT: next_prdata = {16'h0000, stat_byte, 1'b0, rb_s, err,
                                       fail_prev, fail_cur, queued, cb_active,
                                       state != st_idle};
        `NMPC_OFS_RDATA: next_prdata = {24'h000000, rdata};
        `NMPC_OFS_CFG: next_prdata = {28'h0000000, cfg};
        default: next_prdata = 32'h00000000;
      endcase
    end
    if (apb_done && pwrite_in && paddr_in == `NMPC_OFS_CFG)
      next_cfg = pwdata_in[3:0];
    next_pins.wp_n = cfg[`NMPC_CFG_WP_BIT];
    if (wr_cmd && refuse)
      next_err = 1'b1;
    else if (apb_done && pwrite_in && paddr_in == `NMPC_OFS_STAT)
      next_err = 1'b0;

    case (state)
      st_idle:
      begin
        if (cmd_go)
        begin
          next_confirm = 1'b0;
          next_poll = 1'b0;
          next_pins.io_oe = 1'b1;
          next_pins.io = eff;
          next_pins.we_n = 1'b0;
          next_state = st_we_lo;
          case (req_op)
            nmpc_op_cmd:
            begin
              next_pins.cle = 1'b1;
              next_addr_idx = 3'd0;
              // Confirms are followed by busy wait
              next_confirm = (eff == `NMPC_C_PROG) || (eff == `NMPC_C_CACHE) ||
                             (eff == `NMPC_C_QUEUE) || (eff == `NMPC_C_CBREAD) ||
                             (eff == `NMPC_C_RESET);
              if (eff == `NMPC_C_QUEUE)
              begin
                next_queued = 1'b1; // [RULE7]
                next_plane_run = 1'b1;
              end
              if (eff == `NMPC_C_SETUP || eff == `NMPC_C_SETUP2 || eff == `NMPC_C_COLCHG)
                next_queued = 1'b0; // [RULE6]
              if (eff == `NMPC_C_PROG || eff == `NMPC_C_CACHE || eff == `NMPC_C_RESET)
              begin
                next_plane_run = 1'b0;
                next_queued = 1'b0;
              end
              if (eff == `NMPC_C_CBREAD)
              begin
                next_cb_active = 1'b1; // [RULE17]
                next_src_plane = plane;
              end
              if (eff == `NMPC_C_PROG || eff == `NMPC_C_RESET)
                next_cb_active = 1'b0; // [RULE20]
            end
            nmpc_op_addr:
            begin
              next_pins.ale = 1'b1;
              next_addr_idx = addr_idx + 3'd1;
              if (addr_idx == 3'd2)
              begin
                // Plane bit forced in two-plane mode
                if (cfg[`NMPC_CFG_TWOPL_BIT])
                  next_pins.io[`NMPC_ADDR_PLANE_BIT] = plane_run; // [RULE12]
                next_plane = cfg[`NMPC_CFG_TWOPL_BIT] ? plane_run :
                             req_byte[`NMPC_ADDR_PLANE_BIT];
                next_blk_a = req_byte[7];
              end
              if (addr_idx == 3'd3)
                next_blk_b = (req_byte[7:1] == 7'h00);
              if (addr_idx == 3'd4)
                next_blk_c = (req_byte[1:0] == 2'b00);
            end
            nmpc_op_dwr:
            begin
            end
            nmpc_op_drd:
            begin
              next_pins.io_oe = 1'b0;
              next_pins.we_n = 1'b1;
              next_pins.re_n = 1'b0; // [RULE19]
              next_cnt = 4'(`NMPC_RD_CYC);
              next_state = st_re_lo;
            end
            nmpc_op_wait:
            begin
              next_pins.io_oe = 1'b0;
              next_pins.we_n = 1'b1;
              next_state = st_rb;
            end
            default:
            begin
              // Status poll: 70h then reads until ready
              next_pins.cle = 1'b1;
              next_pins.io = `NMPC_C_STATUS;
              next_poll = 1'b1;
              next_poll_arr = req_final; // [RULE2]
            end
          endcase
        end
      end
      st_we_lo:
      begin
        next_pins.we_n = 1'b1;
        next_state = st_we_hi;
      end
      st_we_hi:
      begin
        next_pins.cle = 1'b0;
        next_pins.ale = 1'b0;
        next_pins.io_oe = 1'b0;
        if (confirm)
        begin
          next_cnt = 4'(`NMPC_WB_CYC);
          next_state = st_wb;
        end
        else if (poll)
        begin
          next_pins.re_n = 1'b0;
          next_cnt = 4'(`NMPC_RD_CYC);
          next_state = st_re_lo;
        end
        else
          next_state = st_idle;
      end
      st_re_lo:
      begin
        if (cnt == 4'd0)
        begin
          next_rdata = io_s;
          next_pins.re_n = 1'b1;
          next_state = st_re_hi;
        end
        else
          next_cnt = cnt - 4'd1;
      end
      st_re_hi:
      begin
        if (poll)
        begin
          next_stat_byte = rdata;
          if (rdata[`NMPC_SB_READY])
            next_fail_prev = rdata[`NMPC_SB_PREV]; // [RULE3] [RULE10]
          if (rdata[`NMPC_SB_READY] && rdata[`NMPC_SB_ARRAY])
            next_fail_cur = rdata[`NMPC_SB_CUR]; // [RULE4] [RULE9] [RULE11]
          if (rdata[`NMPC_SB_READY] && (rdata[`NMPC_SB_ARRAY] || !poll_arr))
            next_state = st_idle; // [RULE8] [RULE24]
          else
          begin
            next_pins.re_n = 1'b0;
            next_cnt = 4'(`NMPC_RD_CYC);
            next_state = st_re_lo;
          end
        end
        else
          next_state = st_idle;
      end
      st_wb:
      begin
        if (cnt == 4'd0)
          next_state = st_rb;
        else
          next_cnt = cnt - 4'd1;
      end
      st_rb:
      begin
        if (rb_s)
          next_state = st_idle; // [RULE23] [RULE25]
      end
      default:
      begin
        next_state = st_idle;
      end
    endcase
  end

  // ****************************************
  // Registers
  // ****************************************
  always_ff @(posedge core_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      state <= st_idle;
      pins <= '{cle: 1'b0, ale: 1'b0, ce_n: 1'b0, we_n: 1'b1, re_n: 1'b1,
                wp_n: 1'b0, io: 8'h00, io_oe: 1'b0};
      cfg <= `NMPC_CFG_RESET;
      cnt <= 4'h0;
      rdata <= 8'h00;
      stat_byte <= 8'h00;
      fail_cur <= 1'b0;
      fail_prev <= 1'b0;
      err <= 1'b0;
      confirm <= 1'b0;
      poll <= 1'b0;
      poll_arr <= 1'b0;
      addr_idx <= 3'h0;
      queued <= 1'b0;
      plane_run <= 1'b0;
      plane <= 1'b0;
      blk_a <= 1'b0;
      blk_b <= 1'b0;
      blk_c <= 1'b0;
      cb_active <= 1'b0;
      src_plane <= 1'b0;
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      state <= next_state;
      pins <= next_pins;
      cfg <= next_cfg;
      cnt <= next_cnt;
      rdata <= next_rdata;
      stat_byte <= next_stat_byte;
      fail_cur <= next_fail_cur;
      fail_prev <= next_fail_prev;
      err <= next_err;
      confirm <= next_confirm;
      poll <= next_poll;
      poll_arr <= next_poll_arr;
      addr_idx <= next_addr_idx;
      queued <= next_queued;
      plane_run <= next_plane_run;
      plane <= next_plane;
      blk_a <= next_blk_a;
      blk_b <= next_blk_b;
      blk_c <= next_blk_c;
      cb_active <= next_cb_active;
      src_plane <= next_src_plane;
      prdata <= next_prdata;
      pready <= next_pready;
      pslverr <= next_pslverr;
    end
  end

  assign prdata_out = prdata;
  assign pready_out = pready;
  assign pslverr_out = pslverr;
  assign nand_out = pins;

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb_core @(posedge core_clk_in); endclocking
  default disable iff (!arst_n_in);

  a_rb_only_swap: assert property (cmd_go && req_op == nmpc_op_cmd && req_final && // [RULE1]
    req_byte == `NMPC_C_CACHE && cfg[`NMPC_CFG_RBONLY_BIT] |=> pins.io == `NMPC_C_PROG)
    else $error("cache confirm not swapped to program confirm");
  a_queue_busy: assert property (state == st_we_hi && confirm |=> state == st_wb [*2]) // [RULE7]
    else $error("confirm not followed by busy wait");
  a_busy_hold: assert property (state == st_rb && !rb_s |=> state == st_rb) // [RULE25]
    else $error("left busy wait while pin low");
  a_queue_filter: assert property (wr_cmd && queued && req_op == nmpc_op_cmd && // [RULE15]
    req_byte == `NMPC_C_ERASE |=> err && state == $past(state))
    else $error("illegal command after queue accepted");
  a_boot_guard: assert property (wr_cmd && req_op == nmpc_op_cmd && boot_low && // [RULE5]
    req_byte == `NMPC_C_CACHE && cfg[`NMPC_CFG_BOOT_BIT] && !req_final |=> err)
    else $error("cache program on boot block accepted");
  a_plane_force: assert property (cmd_go && req_op == nmpc_op_addr && addr_idx == 3'd2 && // [RULE12]
    cfg[`NMPC_CFG_TWOPL_BIT] |=> pins.io[`NMPC_ADDR_PLANE_BIT] == $past(plane_run))
    else $error("plane bit not forced");
  a_no_mix: assert property (wr_cmd && req_op == nmpc_op_cmd && plane_run && // [RULE14]
    eff == `NMPC_C_ERASE |=> err)
    else $error("erase accepted inside plane run");
  a_cur_fail: assert property (state == st_re_hi && poll && rdata[`NMPC_SB_READY] && // [RULE4]
    rdata[`NMPC_SB_ARRAY] |=> fail_cur == $past(rdata[`NMPC_SB_CUR]) && state == st_idle)
    else $error("current result not captured");
  a_cb_plane: assert property (wr_cmd && req_op == nmpc_op_cmd && cb_active && // [RULE18]
    eff == `NMPC_C_PROG && plane != src_plane |=> err)
    else $error("cross-plane copy back accepted");

endmodule

// *** dv/nmpc_flash_model.sv ***
// Purpose: Behavioural flash device that answers the host sequencer's pins.
// Assumes: Pins are sampled on the core clock; a write strobe lasts one cycle, a read strobe several.
// Notes:   Busy times are short arbitrary counts; only one page row is kept.
`timescale 1ns/1ps
`include "nmpc_consts.svh"
module nmpc_flash_model
  import nmpc_pkg::*;
#(
  parameter int DBSY = 6,
  parameter int PROG = 40,
  parameter int CBSY = 10,
  parameter int RDT = 12
)
(
  input wire logic clk_in,
  input wire logic fail_in,
  input wire nmpc_pins_s pins_in,
  output logic [7:0] io_out,
  output logic ready_busy_out,
  output logic [7:0] last_cmd_out,
  output logic [7:0] clears_out
);
  // ****************************************
  // Device state
  // ****************************************
  logic [7:0] cache [16];
  logic [7:0] prev_cmd = 8'h00;
  logic [7:0] col = 8'h00;
  logic [7:0] hold = 8'h00;
  logic we_q = 1'b1;
  logic re_q = 1'b1;
  logic stat_mode = 1'b0;
  logic f_cur = 1'b0;
  logic f_prev = 1'b0;
  logic first_addr = 1'b0;
  int cnt = 0;
  int acnt = 0;
  logic [7:0] status_byte;

  initial
  begin
    last_cmd_out = 8'h00;
    clears_out = 8'h00;
    foreach (cache[i]) cache[i] = 8'hff;
  end

  // Pass/fail bits only count once the matching ready bit is set
  assign status_byte = {pins_in.wp_n, cnt == 0, acnt == 0, 3'b000,
                        f_prev & (cnt == 0), f_cur & (acnt == 0)};
  assign ready_busy_out = (cnt == 0);
  // A released bus shows the inverse of the last byte, never a stale copy
  assign io_out = pins_in.re_n ? ~hold : (stat_mode ? status_byte : cache[col[3:0]]);

  // Latch cycles on the rising write strobe; count busy times down
  always @(posedge clk_in)
  begin
    we_q <= pins_in.we_n;
    re_q <= pins_in.re_n;
    if (cnt > 0) cnt <= cnt - 1;
    if (acnt > 0) acnt <= acnt - 1;
    if (!pins_in.re_n) hold <= io_out;
    if (!re_q && pins_in.re_n) col <= col + 8'h01;
    if (!we_q && pins_in.we_n && pins_in.cle)
    begin
      prev_cmd <= pins_in.io;
      last_cmd_out <= pins_in.io;
      first_addr <= 1'b1;
      stat_mode <= (pins_in.io == `NMPC_C_STATUS);
      case (pins_in.io)
        `NMPC_C_SETUP:
          if (prev_cmd != `NMPC_C_QUEUE)
          begin
            clears_out <= clears_out + 8'h01;
            foreach (cache[i]) cache[i] <= 8'hff;
          end
        `NMPC_C_QUEUE:
        begin
          cnt <= DBSY;
          acnt <= DBSY;
        end
        `NMPC_C_PROG:
        begin
          cnt <= PROG;
          acnt <= PROG;
          f_prev <= f_cur;
          f_cur <= fail_in;
        end
        `NMPC_C_CACHE:
        begin
          // Cache moves only after the earlier array work is done
          cnt <= acnt + CBSY;
          acnt <= acnt + CBSY + PROG;
          f_prev <= f_cur;
          f_cur <= fail_in;
        end
        `NMPC_C_CBREAD:
        begin
          cnt <= RDT;
          acnt <= RDT;
          foreach (cache[i]) cache[i] <= 8'h5a ^ 8'(i);
        end
        `NMPC_C_RESET:
        begin
          cnt <= 4;
          acnt <= 4;
        end
        default: ;
      endcase
    end
    else if (!we_q && pins_in.we_n && pins_in.ale)
    begin
      first_addr <= 1'b0;
      if (first_addr) col <= pins_in.io;
    end
    else if (!we_q && pins_in.we_n)
    begin
      cache[col[3:0]] <= pins_in.io;
      col <= col + 8'h01;
    end
  end
endmodule

// *** dv/testbench.sv ***
// Purpose: Self-checking bench of the host sequencer against the device model.
// Assumes: APB answers after one wait state; software polls the busy bit.
// Notes:   Row table drives plain flows; refusals are tested by hand after it.
`timescale 1ns/1ps
`include "nmpc_consts.svh"
`define CHK(nm, ex, got) begin checks++; if ((got) !== (ex)) begin error_cnt++; $display("wrong value %s expected %h seen %h", nm, ex, got); end end
module testbench;
  import nmpc_pkg::*;
  typedef struct packed {
    logic [2:0] op;
    logic [7:0] b;
    logic f;
    logic [7:0] a;
    logic [15:0] m;
    logic [15:0] e;
  } nmpc_row_s;
  localparam logic [7:0] CM = `NMPC_OFS_CMD;
  localparam logic [7:0] ST = `NMPC_OFS_STAT;
  localparam logic [7:0] RD = `NMPC_OFS_RDATA;
  localparam logic [7:0] CF = `NMPC_OFS_CFG;
  logic core_clk_in = 1'b0;
  logic arst_n_in = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic slv_err;
  logic [7:0] io;
  logic rb;
  logic fail = 1'b0;
  logic [7:0] last_cmd;
  logic [7:0] clears;
  logic [31:0] q;
  nmpc_pins_s pins;
  nmpc_row_s rows [0:30];
  nmpc_row_s r;
  int error_cnt = 0;
  int checks = 0;

  // ****************************************
  // Clock, design and device
  // ****************************************
  always #20 core_clk_in = ~core_clk_in;

  nmpc_host dut_u (.core_clk_in(core_clk_in), .arst_n_in(arst_n_in), .psel_in(psel),
    .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata),
    .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr), .io_in(io),
    .ready_busy_in(rb), .nand_out(pins));

  nmpc_flash_model model_u (.clk_in(core_clk_in), .fail_in(fail), .pins_in(pins),
    .io_out(io), .ready_busy_out(rb), .last_cmd_out(last_cmd), .clears_out(clears));

  // ****************************************
  // Bus tasks
  // ****************************************
  // Holds the request until pready is seen high; releases for a full cycle
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk_in);
    penable <= 1'b1;
    do
    begin
      @(posedge core_clk_in);
    end
    while (pready !== 1'b1);
    q = prdata;
    slv_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge core_clk_in);
  endtask

  // Issues one primitive and polls status, with no bound, until the engine goes idle
  task automatic op(input logic [2:0] o, input logic [7:0] b, input logic f);
    apb(1'b1, CM, {15'h0000, f, b, 5'h00, o});
    do
    begin
      apb(1'b0, ST, 32'h0);
    end
    while (q[0] !== 1'b0);
  endtask

  // Five address cycles; third carries the plane bit, boot picks block 0
  task automatic addr5(input logic [7:0] b, input logic boot);
    op(3'd1, 8'h00, 1'b0);
    op(3'd1, 8'h00, 1'b0);
    op(3'd1, b, 1'b0);
    op(3'd1, boot ? 8'h00 : 8'hff, 1'b0);
    op(3'd1, boot ? 8'h00 : 8'h03, 1'b0);
  endtask

  task automatic wrap_up;
    if (error_cnt == 0 && checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // Hang guard, well above the expected run length
  initial
  begin
    repeat (60000) @(posedge core_clk_in);
    error_cnt++;
    wrap_up();
  end

  // ****************************************
  // Main sequence
  // ****************************************
  initial
  begin
    // Two-plane program, copy back with edits, cache run with failures
    rows = '{'{3'd0, 8'h80, 1'b0, ST, 16'h0, 16'h0}, '{3'd7, 8'h00, 1'b0, ST, 16'h0, 16'h0},
      '{3'd2, 8'h5a, 1'b0, ST, 16'h0, 16'h0}, '{3'd0, 8'h11, 1'b0, ST, 16'h4, 16'h4},
      '{3'd0, 8'h80, 1'b0, ST, 16'h0, 16'h0}, '{3'd7, 8'h40, 1'b0, ST, 16'h0, 16'h0},
      '{3'd2, 8'ha5, 1'b0, ST, 16'h0, 16'h0}, '{3'd0, 8'h10, 1'b0, ST, 16'h0, 16'h0},
      '{3'd5, 8'h00, 1'b1, ST, 16'hff08, 16'he000}, '{3'd0, 8'h00, 1'b0, ST, 16'h0, 16'h0},
      '{3'd7, 8'h40, 1'b0, ST, 16'h0, 16'h0}, '{3'd0, 8'h35, 1'b0, ST, 16'h2, 16'h2},
      '{3'd4, 8'h00, 1'b0, ST, 16'h0, 16'h0}, '{3'd3, 8'h00, 1'b0, RD, 16'hff, 16'h5a},
      '{3'd3, 8'h00, 1'b0, RD, 16'hff, 16'h5b}, '{3'd0, 8'h85, 1'b0, ST, 16'h0, 16'h0},
      '{3'd7, 8'h40, 1'b0, ST, 16'h0, 16'h0}, '{3'd2, 8'h77, 1'b0, ST, 16'h0, 16'h0},
      '{3'd0, 8'h10, 1'b0, ST, 16'h0, 16'h0}, '{3'd5, 8'h00, 1'b1, ST, 16'hff08, 16'he000},
      '{3'd6, 8'h01, 1'b0, ST, 16'h0, 16'h0}, '{3'd0, 8'h80, 1'b0, ST, 16'h0, 16'h0},
      '{3'd7, 8'h40, 1'b0, ST, 16'h0, 16'h0}, '{3'd2, 8'h11, 1'b0, ST, 16'h0, 16'h0},
      '{3'd0, 8'h15, 1'b0, ST, 16'h0, 16'h0}, '{3'd5, 8'h00, 1'b0, ST, 16'h10, 16'h0},
      '{3'd0, 8'h80, 1'b0, ST, 16'h0, 16'h0}, '{3'd7, 8'h40, 1'b0, ST, 16'h0, 16'h0},
      '{3'd0, 8'h15, 1'b0, ST, 16'h0, 16'h0}, '{3'd5, 8'h00, 1'b1, ST, 16'h18, 16'h18},
      '{3'd6, 8'h00, 1'b0, ST, 16'h0, 16'h0}};
    repeat (3) @(posedge core_clk_in);
    `CHK("wp_in_reset", 1'b0, pins.wp_n)
    `CHK("we_in_reset", 1'b1, pins.we_n)
    repeat (9) @(posedge core_clk_in);
    arst_n_in <= 1'b1;
    repeat (2) @(posedge core_clk_in);
    apb(1'b0, CF, 32'h0);
    `CHK("cfg_reset", 32'h1, q)
    `CHK("wp_after", 1'b1, pins.wp_n)
    apb(1'b0, 8'h10, 32'h0);
    `CHK("unmapped", 1'b1, slv_err)
    foreach (rows[i])
    begin
      r = rows[i];
      if (r.op == 3'd6) fail <= r.b[0];
      else if (r.op == 3'd7) addr5(r.b, 1'b0);
      else op(r.op, r.b, r.f);
      if (r.m != 16'h0)
      begin
        apb(1'b0, r.a, 32'h0);
        `CHK("row", r.e, q[15:0] & r.m)
      end
      if (i == 17) `CHK("edit", 8'h77, model_u.cache[0])
    end
    `CHK("clears", 8'h03, clears)
    apb(1'b0, ST, 32'h0);
    `CHK("no_err", 1'b0, q[5])
    // Ready/busy-only mode must close the run with a plain confirm
    apb(1'b1, CF, 32'h3);
    op(3'd0, 8'h80, 1'b0);
    addr5(8'h40, 1'b0);
    op(3'd0, 8'h15, 1'b1);
    `CHK("rb_only", 8'h10, last_cmd)
    // Boot guard refuses a cache confirm on block 0
    apb(1'b1, CF, 32'h5);
    op(3'd0, 8'h80, 1'b0);
    addr5(8'h00, 1'b1);
    op(3'd0, 8'h15, 1'b0);
    apb(1'b0, ST, 32'h0);
    `CHK("boot_err", 1'b1, q[5])
    `CHK("boot_pins", 8'h80, last_cmd)
    apb(1'b1, ST, 32'h0);
    op(3'd0, 8'h10, 1'b0);
    apb(1'b1, CF, 32'h9);
    // Erase between queue confirm and next plane is refused
    op(3'd0, 8'h80, 1'b0);
    addr5(8'h00, 1'b0);
    op(3'd0, 8'h11, 1'b0);
    op(3'd0, 8'h60, 1'b0);
    apb(1'b0, ST, 32'h0);
    `CHK("mix_err", 1'b1, q[5])
    `CHK("mix_pins", 8'h11, last_cmd)
    apb(1'b1, ST, 32'h0);
    op(3'd0, 8'h80, 1'b0);
    addr5(8'h40, 1'b0);
    op(3'd0, 8'h10, 1'b0);
    apb(1'b1, CF, 32'h1);
    // Copy back across planes is refused
    op(3'd0, 8'h00, 1'b0);
    addr5(8'h00, 1'b0);
    op(3'd0, 8'h35, 1'b0);
    op(3'd0, 8'h85, 1'b0);
    addr5(8'h40, 1'b0);
    op(3'd0, 8'h10, 1'b0);
    apb(1'b0, ST, 32'h0);
    `CHK("plane_err", 1'b1, q[5])
    `CHK("plane_pins", 8'h85, last_cmd)
    op(3'd0, 8'hff, 1'b0);
    apb(1'b1, ST, 32'h0);
    // Unknown operation code
    apb(1'b1, CM, 32'h7);
    apb(1'b0, ST, 32'h0);
    `CHK("op_err", 1'b1, q[5])
    wrap_up();
  end
endmodule
